// ==== rtl/clkout_pkg.sv ====
package clkout_pkg;
	// Output structure: banks of 4, 4, 2 and 1 differential outputs
	localparam int NUM_DIFF = 11;
	localparam int NUM_BANK = 4;
	localparam int BANK_A = 0;
	localparam int BANK_B = 1;
	localparam int BANK_C = 2;
	localparam int BANK_D = 3;

	// Register byte offsets
	localparam logic [7:0] OFS_FRAC_CTRL = 8'h00;
	localparam logic [7:0] OFS_FRAC_FRACTION = 8'h04;
	localparam logic [7:0] OFS_BANK_CTRL = 8'h08;
	localparam logic [7:0] OFS_OUT_PWRDN = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Fractional control field positions
	localparam int FRAC_INT_LSB = 0;
	localparam int FRAC_POST_LSB = 4;
	localparam int FRAC_AUX_LSB = 8;
	localparam logic [9:0] FRAC_CTRL_RST = 10'h008;
	localparam logic [23:0] FRAC_FRACTION_RST = 24'h000000;
	localparam logic [3:0] INT_PART_MIN = 4'h5;

	// Bank control: one byte per bank
	localparam int BANK_STRIDE = 8;
	localparam int BIT_PIN_CTRL = 0;
	localparam int BIT_PWR_UP = 1;
	localparam int BIT_ENABLE = 2;
	localparam int RATIO_LSB = 4;
	localparam logic [31:0] BANK_CTRL_RST = 32'h07070707;
	localparam logic [10:0] OUT_PWRDN_RST = 11'h000;

	// Status field positions
	localparam int ST_EE_ADDR_LSB = 0;
	localparam int ST_EE_REQ = 7;
	localparam int ST_BANK_ON_LSB = 8;
	localparam int ST_CLK_LSB = 12;

	// Memory loader addresses picked by the bank B straps
	localparam logic [6:0] EE_ADDR_BASE = 7'h50;
	localparam logic [6:0] EE_ADDR_STEP = 7'h02;

	// Strap level codes: 2'b11 counts as middle (weak bias)
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_MID = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;

	typedef enum logic [1:0] {AUX_HIZ, AUX_DIV, AUX_BYP} aux_t;

	// Half period of the output in VCO cycles is (n + f/2^24) << sh
	typedef struct packed {
		logic [7:0] n;
		logic [23:0] f;
		logic [1:0] sh;
	} div_cfg_t;

	// Ratio table indexes
	localparam logic [3:0] RAT_16 = 4'h0;
	localparam logic [3:0] RAT_10 = 4'h1;
	localparam logic [3:0] RAT_8 = 4'h2;
	localparam logic [3:0] RAT_5 = 4'h3;
	localparam logic [3:0] RAT_20 = 4'h4;
	localparam logic [3:0] RAT_25 = 4'h5;
	localparam logic [3:0] RAT_50 = 4'h6;
	localparam logic [3:0] RAT_100 = 4'h7;
	localparam logic [3:0] RAT_18P75 = 4'h8;
	localparam logic [3:0] RAT_37P5 = 4'h9;
	localparam logic [3:0] RAT_75 = 4'ha;

	// Fixed divide ratios, independent of the VCO rate
	function automatic div_cfg_t ratio_cfg(input logic [3:0] idx);
		case (idx)
			RAT_10: return '{8'h05, 24'h000000, 2'h0};
			RAT_8: return '{8'h04, 24'h000000, 2'h0};
			RAT_5: return '{8'h02, 24'h800000, 2'h0};
			RAT_20: return '{8'h0a, 24'h000000, 2'h0};
			RAT_25: return '{8'h0c, 24'h800000, 2'h0};
			RAT_50: return '{8'h19, 24'h000000, 2'h0};
			RAT_100: return '{8'h32, 24'h000000, 2'h0};
			RAT_18P75: return '{8'h09, 24'h600000, 2'h0};
			RAT_37P5: return '{8'h09, 24'h600000, 2'h1};
			RAT_75: return '{8'h09, 24'h600000, 2'h2};
			default: return '{8'h08, 24'h000000, 2'h0};
		endcase
	endfunction

	// Output index to bank number
	function automatic logic [1:0] bank_of(input int i);
		return (i < 4) ? 2'd0 : (i < 8) ? 2'd1 : (i < 10) ? 2'd2 : 2'd3;
	endfunction
endpackage

// ==== rtl/strap_if.sv ====
`timescale 1ns/1ns
interface strap_if;
	import clkout_pkg::*;
	logic [3:0] bank_off;
	logic [3:0] ratio [NUM_BANK];
	aux_t d_aux;
	logic d_use_reg;
	logic eeprom_req;
	logic [6:0] eeprom_addr;
	modport dec (output bank_off, ratio, d_aux, d_use_reg, eeprom_req, eeprom_addr);
	modport use_side (input bank_off, ratio, d_aux, d_use_reg, eeprom_req, eeprom_addr);
endinterface // strap_if

// ==== rtl/strap_decode.sv ====
`timescale 1ns/1ns
module strap_decode import clkout_pkg::*; (
	// Strap pins, {pin1, pin0}, two-bit level each
	input wire logic [3:0] a_pins,
	input wire logic [3:0] b_pins,
	input wire logic [3:0] c_pins,
	input wire logic [3:0] d_pins,
	// Decoded selection
	strap_if.dec sd
);
	function automatic logic [3:0] pair_idx(input logic [3:0] p);
		logic [3:0] hi;
		logic [3:0] lo;
		hi = (p[3:2] == 2'h3) ? 4'(LVL_MID) : 4'(p[3:2]);
		lo = (p[1:0] == 2'h3) ? 4'(LVL_MID) : 4'(p[1:0]);
		return 4'(hi * 4'd3 + lo);
	endfunction

	// Common table for banks A to C, index 4 is power-down
	function automatic logic [3:0] abc_ratio(input logic [3:0] k);
		case (k)
			4'h0: return RAT_16;
			4'h1: return RAT_10;
			4'h2: return RAT_8;
			4'h3: return RAT_5;
			4'h5: return RAT_20;
			4'h6: return RAT_25;
			4'h7: return RAT_50;
			default: return RAT_100;
		endcase
	endfunction

	logic [3:0] ka, kb, kc, kd;
	assign ka = pair_idx(a_pins);
	assign kb = pair_idx(b_pins);
	assign kc = pair_idx(c_pins);
	assign kd = pair_idx(d_pins);

	always_comb begin
		sd.bank_off[0] = (ka == 4'h4);
		sd.bank_off[1] = (kb == 4'h4);
		sd.bank_off[2] = (kc == 4'h4);
		sd.ratio[0] = abc_ratio(ka);
		sd.ratio[1] = abc_ratio(kb);
		sd.ratio[2] = abc_ratio(kc);
		sd.eeprom_req = (ka == 4'h8);
		if (b_pins[3:2] == LVL_HIGH) begin
			sd.eeprom_addr = EE_ADDR_BASE + EE_ADDR_STEP * ((b_pins[1:0] == LVL_HIGH) ? 7'd3 : 7'd2);
		end else begin
			sd.eeprom_addr = EE_ADDR_BASE + ((b_pins[1:0] == LVL_HIGH) ? EE_ADDR_STEP : 7'h00);
		end
		// bank D decode, same process so each field has one writer
		sd.bank_off[3] = 1'b0;
		sd.d_aux = AUX_HIZ;
		sd.d_use_reg = 1'b0;
		sd.ratio[3] = RAT_16;
		case (kd)
			4'h1: sd.ratio[3] = RAT_20;
			4'h2: sd.ratio[3] = RAT_25;
			4'h3: begin
				sd.bank_off[3] = 1'b1;
				sd.d_aux = AUX_DIV;
				sd.ratio[3] = RAT_75;
			end
			4'h4, 4'h5: sd.bank_off[3] = 1'b1;
			4'h6: sd.ratio[3] = RAT_18P75;
			4'h7: sd.ratio[3] = RAT_37P5;
			4'h8: begin
				sd.d_aux = AUX_BYP;
				sd.d_use_reg = 1'b1;
			end
			default: sd.ratio[3] = RAT_16;
		endcase
	end
endmodule // strap_decode

// ==== rtl/frac_divider.sv ====
`timescale 1ns/1ns
module frac_divider import clkout_pkg::*; (
	// Clock and reset; mclk stands in for the VCO
	input wire logic mclk,
	input wire logic rstn,
	// Control
	input wire logic run,
	input wire div_cfg_t cfg,
	// Divided clock level
	output logic clk_o
);
	logic [10:0] cnt_r, cnt_nxt;
	logic [23:0] acc_r, acc_nxt;
	logic out_r, out_nxt;
	logic [25:0] fs;
	logic [24:0] asum;
	logic [10:0] reload;

	assign fs = 26'({2'h0, cfg.f} << cfg.sh);
	assign asum = {1'b0, acc_r} + {1'b0, fs[23:0]};
	assign reload = 11'({3'h0, cfg.n} << cfg.sh) + 11'(fs[25:24]) + 11'(asum[24]);

	// Half-period counter; carries spread the fraction over periods
	always_comb begin
		cnt_nxt = cnt_r - 11'd1;
		acc_nxt = acc_r;
		out_nxt = out_r;
		if (!run) begin
			cnt_nxt = '0;
			acc_nxt = '0;
			out_nxt = 1'b0;
		end else if (cnt_r <= 11'd1) begin
			cnt_nxt = reload;
			acc_nxt = asum[23:0];
			out_nxt = !out_r;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= '0;
			acc_r <= '0;
			out_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			acc_r <= acc_nxt;
			out_r <= out_nxt;
		end
	end
	assign clk_o = out_r;

	property p_half_period;
		@(posedge mclk) disable iff (!rstn)
		run && $changed(out_r) && cfg.n >= 8'h02 ##1 run |-> $stable(out_r);
	endproperty
	a_half_period: assert property (p_half_period) else $error("divider toggled too soon");
endmodule // frac_divider

// ==== rtl/output_divider_pin_select.sv ====
`timescale 1ns/1ns
// How it works
// - Bank D rate is VCO over 2(int+frac)post
// - Integer part 4 bits, 5 to 15
// - Fraction is 24-bit unsigned, any value
// - Post-divider selects 1, 2 or 4
// - Powered-down outputs and auxiliary go high-Z
// - Strap mode: whole bank shares one setting
// - Straps never change stored registers
// - Registers power and enable each bank
// - Disabled: true low, complement high, divided aux low
// - Everything enabled after reset
// - Single-output power-down by register only
// - Strap ratios fixed, frequency follows VCO
// - Bank A strap table, HH memory load
// - Bank B strap table, HH ratio 100
// - Bank C uses bank B table
// - Bank D strap table with auxiliary modes
// - Memory load turns B straps into address
// - Straps are three-level, open reads middle
module output_divider_pin_select import clkout_pkg::*; (
	// Clock (VCO stand-in) and reset
	input wire logic mclk,
	input wire logic rstn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Strap pins, {pin1, pin0}
	input wire logic [3:0] bank_a_strap_pins,
	input wire logic [3:0] bank_b_strap_pins,
	input wire logic [3:0] bank_c_strap_pins,
	input wire logic [3:0] bank_d_strap_pins,
	// Input reference for bypass
	input wire logic ref_in,
	// Differential outputs and CMOS auxiliary output
	output logic [3:0] bank_a_outputs,
	output logic [3:0] bank_a_outputs_n,
	output logic [3:0] bank_a_outputs_oe,
	output logic [3:0] bank_b_outputs,
	output logic [3:0] bank_b_outputs_n,
	output logic [3:0] bank_b_outputs_oe,
	output logic [1:0] bank_c_outputs,
	output logic [1:0] bank_c_outputs_n,
	output logic [1:0] bank_c_outputs_oe,
	output logic bank_d_diff_output,
	output logic bank_d_diff_output_n,
	output logic bank_d_diff_output_oe,
	output logic bank_d_cmos_aux_output,
	output logic bank_d_cmos_aux_output_oe,
	// Memory loader request
	output logic eeprom_load_req,
	output logic [6:0] eeprom_addr
);
	////////////////////////////////////////////////////////////////////////////////
	// Register file

	logic [9:0] frac_ctrl_r, frac_ctrl_nxt;
	logic [23:0] frac_fraction_r, frac_fraction_nxt;
	logic [31:0] bank_ctrl_r, bank_ctrl_nxt;
	logic [10:0] out_pwrdn_r, out_pwrdn_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic [31:0] status;
	logic setup, wr, hit;
	logic [3:0] bank_clk;

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign hit = (paddr == OFS_FRAC_CTRL) || (paddr == OFS_FRAC_FRACTION) ||
		(paddr == OFS_BANK_CTRL) || (paddr == OFS_OUT_PWRDN) || (paddr == OFS_STATUS);
	// Zero wait states; unmapped offsets answer with an error
	assign pready = penable;
	assign pslverr = psel && penable && !hit;
	assign prdata = prdata_r;

	always_comb begin
		frac_ctrl_nxt = frac_ctrl_r;
		frac_fraction_nxt = frac_fraction_r;
		bank_ctrl_nxt = bank_ctrl_r;
		out_pwrdn_nxt = out_pwrdn_r;
		prdata_nxt = prdata_r;
		if (wr) begin
			if (paddr == OFS_FRAC_CTRL) begin
				frac_ctrl_nxt = pwdata[9:0];
			end else if (paddr == OFS_FRAC_FRACTION) begin
				frac_fraction_nxt = pwdata[23:0];
			end else if (paddr == OFS_BANK_CTRL) begin
				bank_ctrl_nxt = pwdata;
			end else if (paddr == OFS_OUT_PWRDN) begin
				out_pwrdn_nxt = pwdata[10:0];
			end
		end
		// Read data fetched during setup, held through access
		if (setup) begin
			if (paddr == OFS_FRAC_CTRL) begin
				prdata_nxt = {22'h0, frac_ctrl_r};
			end else if (paddr == OFS_FRAC_FRACTION) begin
				prdata_nxt = {8'h0, frac_fraction_r};
			end else if (paddr == OFS_BANK_CTRL) begin
				prdata_nxt = bank_ctrl_r;
			end else if (paddr == OFS_OUT_PWRDN) begin
				prdata_nxt = {21'h0, out_pwrdn_r};
			end else if (paddr == OFS_STATUS) begin
				prdata_nxt = status;
			end else begin
				prdata_nxt = '0;
			end
		end
	end

	// Reset leaves all banks strap-driven and enabled
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			frac_ctrl_r <= FRAC_CTRL_RST;
			frac_fraction_r <= FRAC_FRACTION_RST;
			bank_ctrl_r <= BANK_CTRL_RST;
			out_pwrdn_r <= OUT_PWRDN_RST;
			prdata_r <= '0;
		end else begin
			frac_ctrl_r <= frac_ctrl_nxt;
			frac_fraction_r <= frac_fraction_nxt;
			bank_ctrl_r <= bank_ctrl_nxt;
			out_pwrdn_r <= out_pwrdn_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Strap decode and per-bank selection

	strap_if sd ();
	strap_decode u_strap (
		.a_pins(bank_a_strap_pins),
		.b_pins(bank_b_strap_pins),
		.c_pins(bank_c_strap_pins),
		.d_pins(bank_d_strap_pins),
		.sd(sd.dec)
	);

	logic [3:0] pin_mode, bank_off, bank_dis, bank_run;
	div_cfg_t bank_cfg [NUM_BANK];
	div_cfg_t d_reg_cfg;
	logic [3:0] int_part;
	logic [1:0] post;
	aux_t reg_aux;

	// Integer part clamped to its legal floor
	assign int_part = frac_ctrl_r[FRAC_INT_LSB +: 4];
	assign post = frac_ctrl_r[FRAC_POST_LSB +: 2];
	assign reg_aux = aux_t'(frac_ctrl_r[FRAC_AUX_LSB +: 2]);
	assign d_reg_cfg.n = {4'h0, (int_part < INT_PART_MIN) ? INT_PART_MIN : int_part};
	assign d_reg_cfg.f = frac_fraction_r;
	assign d_reg_cfg.sh = (post == 2'h0) ? 2'h0 : (post == 2'h1) ? 2'h1 : 2'h2;

	// Strap mode or register mode per bank
	always_comb begin
		for (int k = 0; k < NUM_BANK; k++) begin
			// During a memory load banks A and B follow registers
			pin_mode[k] = bank_ctrl_r[k * BANK_STRIDE + BIT_PIN_CTRL] &&
				!(sd.eeprom_req && (k == BANK_A || k == BANK_B));
			if (pin_mode[k]) begin
				bank_off[k] = sd.bank_off[k];
				bank_dis[k] = 1'b0;
				bank_cfg[k] = (k == BANK_D && sd.d_use_reg) ? d_reg_cfg : ratio_cfg(sd.ratio[k]);
			end else begin
				bank_off[k] = !bank_ctrl_r[k * BANK_STRIDE + BIT_PWR_UP];
				bank_dis[k] = !bank_ctrl_r[k * BANK_STRIDE + BIT_ENABLE];
				bank_cfg[k] = (k == BANK_D) ? d_reg_cfg :
					ratio_cfg(bank_ctrl_r[k * BANK_STRIDE + RATIO_LSB +: 4]);
			end
			bank_run[k] = !bank_off[k] || (k == BANK_D && pin_mode[k] && sd.d_aux == AUX_DIV);
		end
	end

	// One divider per bank, all clocked from the VCO stand-in
	for (genvar g = 0; g < NUM_BANK; g++) begin : g_div
		frac_divider u_div (
			.mclk(mclk),
			.rstn(rstn),
			.run(bank_run[g]),
			.cfg(bank_cfg[g]),
			.clk_o(bank_clk[g])
		);
	end

	assign status = {16'h0, bank_clk, ~bank_off, sd.eeprom_req, sd.eeprom_addr};

	////////////////////////////////////////////////////////////////////////////////
	// Output drivers

	logic [10:0] q_r, q_nxt, qn_r, qn_nxt, oe_r, oe_nxt;
	logic aux_r, aux_nxt, aux_oe_r, aux_oe_nxt;
	logic ee_req_r, ee_req_nxt;
	logic [6:0] ee_addr_r, ee_addr_nxt;
	aux_t aux_mode;

	// Power-down wins over disable, disable over clock
	always_comb begin
		for (int i = 0; i < NUM_DIFF; i++) begin
			q_nxt[i] = 1'b0;
			qn_nxt[i] = 1'b0;
			oe_nxt[i] = 1'b0;
			if (!(bank_off[bank_of(i)] || (!pin_mode[bank_of(i)] && out_pwrdn_r[i]))) begin
				oe_nxt[i] = 1'b1;
				q_nxt[i] = !bank_dis[bank_of(i)] && bank_clk[bank_of(i)];
				qn_nxt[i] = bank_dis[bank_of(i)] || !bank_clk[bank_of(i)];
			end
		end
		// Auxiliary: divided clock, reference bypass or high-Z
		if (pin_mode[BANK_D]) begin
			aux_mode = sd.d_aux;
		end else if (bank_off[BANK_D] || out_pwrdn_r[NUM_DIFF - 1]) begin
			aux_mode = AUX_HIZ;
		end else begin
			aux_mode = reg_aux;
		end
		aux_oe_nxt = (aux_mode == AUX_DIV) || (aux_mode == AUX_BYP);
		aux_nxt = 1'b0;
		if (aux_mode == AUX_BYP) begin
			aux_nxt = ref_in;
		end else if (aux_mode == AUX_DIV && !(bank_dis[BANK_D] && !pin_mode[BANK_D])) begin
			aux_nxt = bank_clk[BANK_D];
		end
		ee_req_nxt = sd.eeprom_req;
		ee_addr_nxt = sd.eeprom_addr;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			q_r <= '0;
			qn_r <= '0;
			oe_r <= '0;
			aux_r <= 1'b0;
			aux_oe_r <= 1'b0;
			ee_req_r <= 1'b0;
			ee_addr_r <= '0;
		end else begin
			q_r <= q_nxt;
			qn_r <= qn_nxt;
			oe_r <= oe_nxt;
			aux_r <= aux_nxt;
			aux_oe_r <= aux_oe_nxt;
			ee_req_r <= ee_req_nxt;
			ee_addr_r <= ee_addr_nxt;
		end
	end

	assign bank_a_outputs = q_r[3:0];
	assign bank_a_outputs_n = qn_r[3:0];
	assign bank_a_outputs_oe = oe_r[3:0];
	assign bank_b_outputs = q_r[7:4];
	assign bank_b_outputs_n = qn_r[7:4];
	assign bank_b_outputs_oe = oe_r[7:4];
	assign bank_c_outputs = q_r[9:8];
	assign bank_c_outputs_n = qn_r[9:8];
	assign bank_c_outputs_oe = oe_r[9:8];
	assign bank_d_diff_output = q_r[10];
	assign bank_d_diff_output_n = qn_r[10];
	assign bank_d_diff_output_oe = oe_r[10];
	assign bank_d_cmos_aux_output = aux_r;
	assign bank_d_cmos_aux_output_oe = aux_oe_r;
	assign eeprom_load_req = ee_req_r;
	assign eeprom_addr = ee_addr_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	property p_apb_answer;
		s_setup ##1 s_access |-> pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("no zero-wait answer");

	property p_int_min;
		d_reg_cfg.n >= {4'h0, INT_PART_MIN} && d_reg_cfg.n <= 8'h0f;
	endproperty
	a_int_min: assert property (p_int_min) else $error("integer part out of range");

	property p_pwrdn_hiz;
		bank_off[BANK_A] |=> bank_a_outputs_oe == 4'h0;
	endproperty
	a_pwrdn_hiz: assert property (p_pwrdn_hiz) else $error("powered-down bank driven");

	property p_strap_same;
		pin_mode[BANK_C] && !bank_off[BANK_C] |=> bank_c_outputs_oe == 2'h3;
	endproperty
	a_strap_same: assert property (p_strap_same) else $error("strap bank not uniform");

	property p_regs_kept;
		!wr |=> $stable(bank_ctrl_r) && $stable(frac_ctrl_r) && $stable(out_pwrdn_r);
	endproperty
	a_regs_kept: assert property (p_regs_kept) else $error("register changed w/o write");

	property p_disabled;
		!pin_mode[BANK_D] && bank_dis[BANK_D] && !bank_off[BANK_D] && !out_pwrdn_r[10] |=>
			!bank_d_diff_output && bank_d_diff_output_n && bank_d_diff_output_oe &&
			!bank_d_cmos_aux_output;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled levels wrong");

	property p_reset_on;
		$past(!rstn) |-> bank_ctrl_r == BANK_CTRL_RST;
	endproperty
	a_reset_on: assert property (p_reset_on) else $error("not enabled after reset");

	property p_eeprom;
		bank_a_strap_pins == {LVL_HIGH, LVL_HIGH} |-> !pin_mode[BANK_B] ##1 eeprom_load_req;
	endproperty
	a_eeprom: assert property (p_eeprom) else $error("memory load select missed");

	property p_undef_d;
		pin_mode[BANK_D] && bank_d_strap_pins == {LVL_MID, LVL_HIGH} |=>
			!bank_d_diff_output_oe && !bank_d_cmos_aux_output_oe;
	endproperty
	a_undef_d: assert property (p_undef_d) else $error("undefined D code drives");

	property p_bypass;
		pin_mode[BANK_D] && sd.d_aux == AUX_BYP |=>
			bank_d_cmos_aux_output_oe && bank_d_cmos_aux_output == $past(ref_in);
	endproperty
	a_bypass: assert property (p_bypass) else $error("reference bypass wrong");
endmodule // output_divider_pin_select

// ==== tb/clk_receiver.sv ====
`timescale 1ns/1ns
// Downstream receivers: cycles spanned by four rising edges
module clk_receiver (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Watched lanes, level and drive enable
	input wire logic [4:0] q,
	input wire logic [4:0] oe,
	// Cycles per four periods
	output logic [15:0] span [5]
);
	logic [4:0] prev_r;
	logic [15:0] cnt_r [5];
	logic [1:0] edg_r [5];
	////////////////////////////////////////
	// A floating pin reads low, so a powered-down lane shows no edges
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prev_r <= 5'h00;
			for (int i = 0; i < 5; i++) begin
				cnt_r[i] <= 16'h0000;
				edg_r[i] <= 2'h0;
				span[i] <= 16'h0000;
			end
		end else begin
			prev_r <= q & oe;
			for (int i = 0; i < 5; i++) begin
				cnt_r[i] <= cnt_r[i] + 16'h0001;
				if (q[i] && oe[i] && !prev_r[i]) begin
					edg_r[i] <= edg_r[i] + 2'h1;
					if (edg_r[i] == 2'h3) begin
						span[i] <= cnt_r[i];
						cnt_r[i] <= 16'h0001;
					end
				end
			end
		end
	end
endmodule // clk_receiver

// ==== tb/output_divider_pin_select_tb_top.sv ====
`timescale 1ns/1ns
module output_divider_pin_select_tb_top;
	import clkout_pkg::*;
	logic mclk, rstn, psel, penable, pwrite, pready, pslverr, ref_in, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] a_s, b_s, c_s, d_s, qa, qa_n, qa_oe, qb, qb_n, qb_oe;
	logic [1:0] qc, qc_n, qc_oe;
	logic qd, qd_n, qd_oe, qx, qx_oe, ee_req;
	logic [6:0] ee_addr;
	logic [15:0] span [5];
	int bad_count, n_compared, cyc;
	logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9, 4'ha};
	int abc [8] = '{64, 40, 32, 20, 80, 100, 200, 400};
	logic [3:0] dcodes [5] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9};
	int dsp [5] = '{64, 80, 100, 75, 150};
	logic [3:0] eb [4] = '{4'h0, 4'h2, 4'h8, 4'ha};
	logic [6:0] ea [4] = '{7'h50, 7'h52, 7'h54, 7'h56};

	output_divider_pin_select DUT (.mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bank_a_strap_pins(a_s),
		.bank_b_strap_pins(b_s), .bank_c_strap_pins(c_s), .bank_d_strap_pins(d_s),
		.ref_in(ref_in), .bank_a_outputs(qa), .bank_a_outputs_n(qa_n),
		.bank_a_outputs_oe(qa_oe), .bank_b_outputs(qb), .bank_b_outputs_n(qb_n),
		.bank_b_outputs_oe(qb_oe), .bank_c_outputs(qc), .bank_c_outputs_n(qc_n),
		.bank_c_outputs_oe(qc_oe), .bank_d_diff_output(qd), .bank_d_diff_output_n(qd_n),
		.bank_d_diff_output_oe(qd_oe), .bank_d_cmos_aux_output(qx),
		.bank_d_cmos_aux_output_oe(qx_oe), .eeprom_load_req(ee_req), .eeprom_addr(ee_addr));
	clk_receiver rx (.mclk(mclk), .rstn(rstn), .q({qx, qd, qc[1], qb[0], qa[0]}),
		.oe({qx_oe, qd_oe, qc_oe[1], qb_oe[0], qa_oe[0]}), .span(span));

	////////////////////////////////////////
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Setup then access, held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// Only the hang guard ends a wait that never sees pready
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 1, pready);
	endtask
	task rreg(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("rdata", e, rd);
		chk("slverr", 0, er);
	endtask
	task settle;
		repeat (3) @(posedge mclk);
	endtask
	task straps(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c, input logic [3:0] d);
		@(posedge mclk);
		a_s <= a;
		b_s <= b;
		c_s <= c;
		d_s <= d;
		settle();
	endtask
	// Long wait lets a window straddling the change drop out
	task meas(input int i, input int e);
		repeat (1000) @(posedge mclk);
		chk("span", e, {16'h0, span[i]});
	endtask

	////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Hang guard, well above the expected run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		{rstn, psel, penable, pwrite, ref_in} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		{a_s, b_s, c_s, d_s} = 16'h0000;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		rreg(OFS_FRAC_CTRL, 32'h008);
		rreg(OFS_FRAC_FRACTION, 32'h0);
		rreg(OFS_BANK_CTRL, 32'h07070707);
		rreg(OFS_OUT_PWRDN, 32'h0);
		for (int i = 0; i < 8; i++) begin
			straps(i < 7 ? codes[i] : 4'h0, codes[i], codes[i], 4'h0);
			meas(0, i < 7 ? abc[i] : 64);
			chk("span_b", abc[i], span[1]);
			chk("span_c", abc[i], span[2]);
			chk("b_oe", 4'hf, qb_oe);
		end
		for (int i = 0; i < 5; i++) begin
			straps(4'h0, 4'h0, 4'h0, dcodes[i]);
			meas(3, dsp[i]);
			chk("aux_oe", 0, qx_oe);
		end
		straps(4'h0, 4'h0, 4'h0, 4'h4);
		meas(4, 300);
		chk("d_oe", 0, qd_oe);
		straps(4'h0, 4'h0, 4'h0, 4'h6);
		chk("d_oe", 0, qd_oe);
		chk("aux_oe", 0, qx_oe);
		straps(4'h0, 4'h0, 4'h0, 4'ha);
		ref_in <= 1'b1;
		settle();
		// Both drivers on, auxiliary follows the reference
		chk("aux", 3'h7, {qx_oe, qd_oe, qx});
		ref_in <= 1'b0;
		settle();
		chk("aux", 0, qx);
		straps(4'h5, 4'h5, 4'hf, 4'h5);
		chk("all_oe", 0, {qa_oe, qb_oe, qc_oe, qd_oe, qx_oe});
		chk("pd_n", 0, {qb_n, qc_n});
		straps(4'h0, 4'hb, 4'h0, 4'h0);
		meas(1, 200);
		for (int i = 0; i < 4; i++) begin
			straps(4'ha, eb[i], 4'h0, 4'h0);
			chk("ee_req", 1, ee_req);
			chk("ee_addr", ea[i], ee_addr);
		end
		straps(4'h0, 4'h0, 4'h0, 4'h0);
		chk("ee_req", 0, ee_req);
		rreg(OFS_BANK_CTRL, 32'h07070707);
		apb(1'b1, OFS_BANK_CTRL, 32'h07070746);
		meas(0, 80);
		rreg(OFS_BANK_CTRL, 32'h07070746);
		apb(1'b1, OFS_OUT_PWRDN, 32'h012);
		settle();
		chk("a_oe", 4'hd, qa_oe);
		chk("b_oe", 4'hf, qb_oe);
		apb(1'b1, OFS_OUT_PWRDN, 32'h0);
		apb(1'b1, OFS_BANK_CTRL, 32'h07070742);
		settle();
		chk("a_dis", 12'h0ff, {qa, qa_n, qa_oe});
		apb(1'b1, OFS_BANK_CTRL, 32'h07070740);
		settle();
		chk("a_oe", 0, qa_oe);
		apb(1'b1, OFS_FRAC_CTRL, 32'h10a);
		apb(1'b1, OFS_BANK_CTRL, 32'h06070707);
		meas(3, 80);
		chk("span_aux", 80, span[4]);
		apb(1'b1, OFS_FRAC_FRACTION, 32'h800000);
		for (int p = 0; p < 3; p++) begin
			apb(1'b1, OFS_FRAC_CTRL, 32'h105 | (p << 4));
			meas(3, 44 << p);
		end
		apb(1'b1, OFS_FRAC_FRACTION, 32'hffffffff);
		rreg(OFS_FRAC_FRACTION, 32'h00ffffff);
		apb(1'b1, OFS_FRAC_FRACTION, 32'h0);
		// Integer codes below five run as five
		apb(1'b1, OFS_FRAC_CTRL, 32'h102);
		meas(3, 40);
		apb(1'b1, OFS_FRAC_CTRL, 32'h10f);
		meas(3, 120);
		apb(1'b1, OFS_BANK_CTRL, 32'h02070707);
		settle();
		// Aux enable stays up while disabled, its level low
		chk("d_dis", 5'h0d, {qd, qd_n, qd_oe, qx, qx_oe});
		apb(1'b0, 8'h14, 32'h0);
		chk("slverr", 1, er);
		chk("rdata", 0, rd);
		print_verdict();
	end
endmodule // output_divider_pin_select_tb_top
